//--- imbt_defines.svh
/*
 * Timing counts and counter width for the I2C master bit timing generator.
 * Assumes the counting clock is the processor bus clock that drives ref_clk.
 */
`ifndef IMBT_DEFINES_SVH
`define IMBT_DEFINES_SVH

// ****************************************************************
// bus phase counts in processor bus clock cycles
// ****************************************************************
`define IMBT_HALF_PERIOD   16'd512
`define IMBT_STOP_SETUP    16'd512
`define IMBT_START_SETUP   16'd1024
`define IMBT_START_HOLD    16'd512
`define IMBT_DATA_VALID    16'd256
`define IMBT_BUS_FREE      16'd512
`define IMBT_COUNT_W       16

`endif

//--- imbt_master.sv
/*
 * I2C master bit timing generator: frames start, bit cells and stop on
 * open-drain clock and data lines from processor bus clock counts; start setup also waits for the clock line to read high.
 * Assumes the user side holds byte-free bit requests: one bit per bitReq
 * pulse, stopReq once after the last bit. Pull-ups live outside.
 */
// Contract
// R1: stop: clock high 512 cycles, then data high
// R2: start: clock high 1024 cycles, then data low
// R3: after start fall wait 512 before clock low
// R4: new bit 256 cycles after clock falls
// R5: old bit held 256 cycles after clock falls
// R6: counter-timed phases; lines only pulled low
`timescale 1ns/1ps
`default_nettype none
`include "imbt_defines.svh"
module imbt_master
   import imbt_pkg::*;
#(
   parameter int COUNT_W = `IMBT_COUNT_W
) (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic startReq,
   input  wire logic bitReq,
   input  wire logic bitValue,
   input  wire logic stopReq,
   input  wire logic sclIn,
   input  wire logic sdaIn,
   output logic      sclOut,
   output logic      sclOe,
   output logic      sdaOut,
   output logic      sdaOe,
   output logic      busy,
   output logic      bitDone,
   output logic      sampledBit
);
   initial begin
      if (COUNT_W < 11) begin
         $error("COUNT_W too narrow for 1024 cycle phases");
      end
   end

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      imbt_state_t        phase;
      logic [COUNT_W-1:0] count;
      logic               pendBit;
      logic               sclLow;
      logic               sdaLow;
      logic               busy;
      logic               bitDone;
      logic               sampledBit;
      logic               awaitBit;
   } imbt_master_t;

   imbt_master_t st;
   imbt_master_t next_st;
   logic         sclSync;
   logic         sdaSync;

   imbt_sync u_scl_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .asyncIn (sclIn),
      .syncOut (sclSync)
   );

   imbt_sync u_sda_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .asyncIn (sdaIn),
      .syncOut (sdaSync)
   );

   function automatic logic expired(input logic [COUNT_W-1:0] cnt, input logic [15:0] lim);
      expired = (cnt == COUNT_W'(lim - 16'd1));
   endfunction

   // ****************************************************************
   // phase sequencer
   // ****************************************************************
   always_comb begin
      next_st         = st;
      next_st.count   = st.count + COUNT_W'(1); // R6
      next_st.bitDone = 1'b0;
      unique case (st.phase)
         ST_IDLE: begin
            next_st.count  = '0;
            next_st.sclLow = 1'b0;
            next_st.sdaLow = 1'b0;
            next_st.busy   = 1'b0;
            if (startReq) begin
               next_st.phase = ST_START_SETUP;
               next_st.busy  = 1'b1;
            end
         end
         ST_START_SETUP: begin
            // waits on the synced clock so a slave holding it low stretches setup
            if (!sclSync) begin
               next_st.count = '0;
            end else if (expired(st.count, `IMBT_START_SETUP)) begin // R2
               next_st.sdaLow = 1'b1;
               next_st.count  = '0;
               next_st.phase  = ST_START_HOLD;
            end
         end
         ST_START_HOLD: begin
            if (expired(st.count, `IMBT_START_HOLD)) begin // R3
               next_st.sclLow   = 1'b1;
               next_st.count    = '0;
               next_st.awaitBit = 1'b1;
               next_st.phase    = ST_LOW_HOLD;
            end
         end
         ST_LOW_HOLD: begin
            // clock is low; the old level stays until the hold count ends
            if (bitReq && st.awaitBit) begin
               next_st.pendBit  = bitValue;
               next_st.awaitBit = 1'b0;
               // a late request finds the count parked; stepping on would skip the match
               if (expired(st.count, `IMBT_DATA_VALID)) begin // R4
                  next_st.count = st.count;
               end
            end else if (stopReq && st.awaitBit) begin
               next_st.awaitBit = 1'b0;
               next_st.pendBit  = 1'b0;
               next_st.count    = '0;
               next_st.phase    = ST_STOP_LOW;
            end
            if (st.awaitBit && !bitReq && !stopReq) begin
               next_st.count = st.count; // count climbs to 255, then holds there until the user decides
               if (st.count != COUNT_W'(`IMBT_DATA_VALID - 16'd1)) begin
                  next_st.count = st.count + COUNT_W'(1);
               end
            end else if (!st.awaitBit && expired(st.count, `IMBT_DATA_VALID)) begin // R5 R4
               next_st.sdaLow = ~st.pendBit;
               next_st.count  = '0;
               next_st.phase  = ST_LOW_VALID;
            end
         end
         ST_LOW_VALID: begin
            if (expired(st.count, `IMBT_DATA_VALID)) begin
               next_st.sclLow = 1'b0;
               next_st.count  = '0;
               next_st.phase  = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (expired(st.count, `IMBT_DATA_VALID)) begin
               next_st.sampledBit = sdaSync;
            end
            if (expired(st.count, `IMBT_HALF_PERIOD)) begin
               next_st.sclLow   = 1'b1;
               next_st.count    = '0;
               next_st.bitDone  = 1'b1;
               next_st.awaitBit = 1'b1;
               next_st.phase    = ST_LOW_HOLD;
            end
         end
         ST_STOP_LOW: begin
            if (expired(st.count, `IMBT_DATA_VALID)) begin
               next_st.sdaLow = 1'b1;
            end
            if (expired(st.count, `IMBT_HALF_PERIOD)) begin
               next_st.sclLow = 1'b0;
               next_st.count  = '0;
               next_st.phase  = ST_STOP_SETUP;
            end
         end
         ST_STOP_SETUP: begin
            if (expired(st.count, `IMBT_STOP_SETUP)) begin // R1
               next_st.sdaLow = 1'b0;
               next_st.count  = '0;
               next_st.phase  = ST_BUS_FREE;
            end
         end
         ST_BUS_FREE: begin
            if (expired(st.count, `IMBT_BUS_FREE)) begin
               next_st.phase = ST_IDLE;
            end
         end
      endcase
      if (!rst_n) begin
         next_st       = '0;
         next_st.phase = ST_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      st <= next_st;
   end

   // ****************************************************************
   // open-drain pins
   // ****************************************************************
   assign sclOut     = 1'b0; // R6
   assign sdaOut     = 1'b0; // R6
   assign sclOe      = st.sclLow;
   assign sdaOe      = st.sdaLow;
   assign busy       = st.busy;
   assign bitDone    = st.bitDone;
   assign sampledBit = st.sampledBit;
endmodule // imbt_master
`default_nettype wire

//--- imbt_master_properties.sv
/* checker for the imbt_master line timing, bound to its ports.
   assumes pull-ups outside and no clock stretching once a frame runs */
`timescale 1ns/1ps
`default_nettype none
module imbt_master_properties (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic startReq,
   input wire logic sclIn,
   input wire logic sclOut,
   input wire logic sclOe,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic busy,
   input wire logic bitDone
);
   // ****
   // cycles since the last line change
   // ****
   logic [11:0] cnt;
   // saturates so a long idle never wraps into a short gap
   always_ff @(posedge ref_clk) begin
      if (!rst_n) cnt <= 12'h000;
      else if ($changed(sclIn) || $changed(sclOe) || $changed(sdaOe)) cnt <= 12'h001;
      else if (cnt != 12'hFFF) cnt <= cnt + 12'h001;
   end
   chk_open_drain: assert property (@(posedge ref_clk) disable iff (!rst_n) !sclOut && !sdaOut)
      else $error("line driven high");
   chk_stop_setup: assert property (@(posedge ref_clk) disable iff (!rst_n) $fell(sdaOe) && !sclOe |-> cnt == 12'd512)
      else $error("stop setup wrong");
   chk_start_setup: assert property (@(posedge ref_clk) disable iff (!rst_n) $rose(sdaOe) && !sclOe |-> cnt >= 12'd1024)
      else $error("start setup short");
   chk_clk_fall: assert property (@(posedge ref_clk) disable iff (!rst_n) $rose(sclOe) |-> cnt == 12'd512)
      else $error("clock fell off time");
   chk_data_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) $changed(sdaOe) && sclOe |-> cnt >= 12'd256)
      else $error("data moved early");
   chk_done_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n) bitDone |-> sclOe ##1 !bitDone)
      else $error("bit done misplaced");
   chk_idle_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) !busy |-> !sclOe && !sdaOe)
      else $error("lines pulled while idle");
   chk_busy_start: assert property (@(posedge ref_clk) disable iff (!rst_n) startReq && !busy |=> busy)
      else $error("start not taken");
endmodule // imbt_master_properties
bind imbt_master imbt_master_properties chk (.ref_clk, .rst_n, .startReq, .sclIn, .sclOut, .sclOe, .sdaOut,
   .sdaOe, .busy, .bitDone);
`default_nettype wire

//--- imbt_master_tb.sv
/* bench for imbt_master with the slave stand-in.
   assumes pull-ups on both lines */
`timescale 1ns/1ps
`default_nettype none
module imbt_master_tb;
   logic ref_clk, rst_n, startReq, bitReq, bitValue, stopReq, holdClk, ackLow;
   logic sclOut, sdaOut, sclOe, sdaOe, busy, bitDone, sampledBit, sclPull, sdaPull;
   wire logic sclLine = !(sclOe || sclPull);
   wire logic sdaLine = !(sdaOe || sdaPull);
   int failures, tests_run, tf;
   int cyc = 0;
   imbt_master uut (.ref_clk, .rst_n, .startReq, .bitReq, .bitValue, .stopReq, .sclIn(sclLine),
      .sdaIn(sdaLine), .sclOut, .sclOe, .sdaOut, .sdaOe, .busy, .bitDone, .sampledBit);
   imbt_slave_model peer (.ref_clk, .rst_n, .sclLine, .holdClk, .ackLow, .sclPull, .sdaPull);
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end
   // ****
   // shared tasks
   // ****
   task automatic results();
      if (failures == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %0d seen %0d", what, exp, seen);
      end
   endtask
   task automatic waitOe(input logic onData, input logic lvl, output int t);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (((onData ? sdaOe : sclOe) !== lvl) && n < 3000);
      t = cyc;
   endtask
   // ****
   // scenarios
   // ****
   task automatic startTest();
      int t0, t1;
      @(posedge ref_clk);
      holdClk <= 1'b1;
      startReq <= 1'b1;
      @(posedge ref_clk);
      startReq <= 1'b0;
      repeat (300) @(posedge ref_clk);
      holdClk <= 1'b0;
      t0 = cyc;
      waitOe(1'b1, 1'b1, t1);
      check("start setup", 16'(t1 - t0 >= 1024), 16'h0001);
      waitOe(1'b0, 1'b1, tf);
      check("start hold", 16'(tf - t1), 16'h0200);
   endtask
   task automatic sendBit(input logic v, input logic ack);
      logic old;
      int ta, tb;
      old = sdaOe;
      @(posedge ref_clk);
      bitReq <= 1'b1;
      bitValue <= v;
      ackLow <= ack;
      @(posedge ref_clk);
      bitReq <= 1'b0;
      while (cyc < tf + 254) @(posedge ref_clk);
      #1;
      check("data hold", 16'(sdaOe), 16'(old));
      @(posedge ref_clk);
      #1;
      check("data valid", 16'(sdaOe), 16'(!v));
      waitOe(1'b0, 1'b0, ta);
      waitOe(1'b0, 1'b1, tb);
      check("clock high", 16'(tb - ta), 16'h0200);
      check("bit done", 16'(bitDone), 16'h0001);
      check("sampled bit", 16'(sampledBit), 16'(v && !ack));
      tf = tb;
   endtask
   task automatic stopTest();
      int ta, tb;
      @(posedge ref_clk);
      stopReq <= 1'b1;
      ackLow <= 1'b0;
      @(posedge ref_clk);
      stopReq <= 1'b0;
      waitOe(1'b0, 1'b0, ta);
      waitOe(1'b1, 1'b0, tb);
      check("stop setup", 16'(tb - ta), 16'h0200);
      check("stop level", 16'(sdaLine), 16'h0001);
      check("busy in free time", 16'(busy), 16'h0001);
      repeat (514) @(posedge ref_clk);
      #1;
      check("busy after free time", 16'(busy), 16'h0000);
   endtask
   initial begin
      {rst_n, startReq, bitReq, bitValue, stopReq, holdClk, ackLow} = 7'h00;
      {failures, tests_run, tf} = '0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      startTest();
      sendBit(1'b0, 1'b0);
      sendBit(1'b1, 1'b0);
      sendBit(1'b1, 1'b1);
      stopTest();
      results();
   end
endmodule // imbt_master_tb
`default_nettype wire

//--- imbt_pkg.sv
/*
 * Types shared by the I2C master bit timing generator.
 * Assumes imbt_defines.svh is on the include path.
 */
package imbt_pkg;
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_START_SETUP,
      ST_START_HOLD,
      ST_LOW_HOLD,
      ST_LOW_VALID,
      ST_HIGH,
      ST_STOP_LOW,
      ST_STOP_SETUP,
      ST_BUS_FREE
   } imbt_state_t;
endpackage

//--- imbt_slave_model.sv
/* slave stand-in: stretches the clock and pulls data low on command.
   assumes the bench resolves both open-drain wires */
`timescale 1ns/1ps
`default_nettype none
module imbt_slave_model (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic sclLine,
   input  wire logic holdClk,
   input  wire logic ackLow,
   output logic      sclPull,
   output logic      sdaPull
);
   // ****
   // data moves only while the clock is low
   // ****
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sdaPull <= 1'b0;
         sclPull <= 1'b0;
      end else begin
         if (!sclLine) sdaPull <= ackLow;
         sclPull <= holdClk;
      end
   end
endmodule // imbt_slave_model
`default_nettype wire

//--- imbt_sync.sv
/*
 * Two flip-flop synchroniser for one level input.
 * Assumes the input may change at any time relative to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module imbt_sync (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic asyncIn,
   output logic      syncOut
);
   typedef struct packed {
      logic stage1;
      logic stage2;
   } imbt_sync_t;

   imbt_sync_t st;
   imbt_sync_t next_st;

   always_comb begin
      next_st.stage1 = asyncIn;
      next_st.stage2 = st.stage1;
      if (!rst_n) begin
         next_st = 2'b11;
      end
   end

   always_ff @(posedge ref_clk) begin
      st <= next_st;
   end

   assign syncOut = st.stage2;
endmodule // imbt_sync
`default_nettype wire
